// >>> logic/dsr_pkg.sv
// Constants, types and helpers for the display status readback block
package dsr_pkg;

   // Read command codes
   localparam logic [7:0] CMD_STATUS_WORD_READ = 8'h09;
   localparam logic [7:0] CMD_POWER_MODE_READ = 8'h0a;
   localparam logic [7:0] CMD_MEMORY_ACCESS_READ = 8'h0b;
   localparam logic [7:0] CMD_PIXEL_FORMAT_READ = 8'h0c;
   localparam logic [7:0] CMD_IMAGE_MODE_READ = 8'h0d;

   // Response lengths in bytes
   localparam int unsigned STATUS_BYTES = 4;
   localparam int unsigned SHORT_BYTES = 1;

   // Status word field positions
   localparam int unsigned ST_BOOSTER_POS = 31;
   localparam int unsigned ST_MAC_LSB = 26;
   localparam int unsigned ST_RSV_HI_LSB = 23;
   localparam int unsigned ST_PIXFMT_LSB = 20;
   localparam int unsigned ST_IDLE_POS = 19;
   localparam int unsigned ST_PARTIAL_POS = 18;
   localparam int unsigned ST_SLEEP_OUT_POS = 17;
   localparam int unsigned ST_NORMAL_POS = 16;
   localparam int unsigned ST_RSV_MID_LSB = 14;
   localparam int unsigned ST_INVERT_POS = 13;
   localparam int unsigned ST_ALL_ON_POS = 12;
   localparam int unsigned ST_ALL_OFF_POS = 11;
   localparam int unsigned ST_DISP_ON_POS = 10;
   localparam int unsigned ST_TE_ON_POS = 9;
   localparam int unsigned ST_GAMMA_LSB = 6;
   localparam int unsigned ST_TE_MODE_POS = 5;
   localparam int unsigned ST_SYNC_LSB = 1;
   localparam int unsigned ST_PARITY_POS = 0;

   // Fixed field values
   localparam logic [2:0] ST_PIXFMT_FIXED = 3'h7;
   localparam logic [2:0] GAMMA_NONE = 3'h7;

   // Pixel format readback reset value and its halves
   localparam logic [7:0] PIXFMT_RST = 8'h67;
   localparam logic [2:0] RGB_FMT_RST = PIXFMT_RST[6:4];
   localparam logic [2:0] HOST_FMT_RST = PIXFMT_RST[2:0];

   // Memory access control bits B7..B3
   typedef logic [4:0] dsr_mac_t;

   // Sync line levels, order matches status bits D4..D1
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic pclk;
      logic data_enable_line;
   } dsr_sync_t;

   // Mode state reported by the readbacks
   typedef struct packed {
      dsr_mac_t memory_access_control;
      logic idle;
      logic partial;
      logic sleep_out;
      logic normal;
      logic disp_on;
      logic invert;
      logic all_on;
      logic all_off;
      logic te_on;
      logic te_mode;
      logic gamma_chosen;
      logic [1:0] gamma_curve;
      logic rgb_mode;
   } dsr_mode_t;

   // Readback words built from the mode state, sync levels and port formats
   typedef struct packed {
      logic [31:0] status_word;
      logic [7:0] power_mode;
      logic [7:0] memory_access;
      logic [7:0] pixel_format;
      logic [7:0] image_mode;
   } dsr_words_t;

   // Gamma code shared by status word and image mode readback
   function automatic logic [2:0] dsr_gamma_code(input logic chosen, input logic [1:0] curve);
      logic [2:0] code;
      code = chosen ? {1'b0, curve} : GAMMA_NONE;
      return code;
   endfunction

endpackage

// >>> logic/dsr_status_pack.sv
// Combinational assembly of all readback words from the mode state, sync levels and port formats
`timescale 1ns/100ps
module dsr_status_pack
(
   input wire dsr_pkg::dsr_mode_t mode,
   input wire dsr_pkg::dsr_sync_t ext_sync,
   input wire dsr_pkg::dsr_sync_t int_sync,
   input wire logic [2:0] rgb_port_format,
   input wire logic [2:0] host_port_format,
   output dsr_pkg::dsr_words_t words
);

   logic [2:0] gamma;
   dsr_pkg::dsr_sync_t sync_sel;

   always_comb
   begin
      gamma = dsr_pkg::dsr_gamma_code(mode.gamma_chosen, mode.gamma_curve);
      sync_sel = mode.rgb_mode ? ext_sync : int_sync;
      words = '0;
      words.status_word[dsr_pkg::ST_BOOSTER_POS] = 1'b0;
      words.status_word[dsr_pkg::ST_MAC_LSB +: 5] = mode.memory_access_control;
      words.status_word[dsr_pkg::ST_RSV_HI_LSB +: 3] = 3'h0;
      words.status_word[dsr_pkg::ST_RSV_MID_LSB +: 2] = 2'h0;
      words.status_word[dsr_pkg::ST_PARITY_POS] = 1'b0;
      words.status_word[dsr_pkg::ST_PIXFMT_LSB +: 3] = dsr_pkg::ST_PIXFMT_FIXED;
      words.status_word[dsr_pkg::ST_IDLE_POS] = mode.idle;
      words.status_word[dsr_pkg::ST_PARTIAL_POS] = mode.partial;
      words.status_word[dsr_pkg::ST_NORMAL_POS] = mode.normal;
      words.status_word[dsr_pkg::ST_SLEEP_OUT_POS] = mode.sleep_out;
      words.status_word[dsr_pkg::ST_INVERT_POS] = mode.invert;
      words.status_word[dsr_pkg::ST_ALL_ON_POS] = mode.all_on;
      words.status_word[dsr_pkg::ST_ALL_OFF_POS] = mode.all_off;
      words.status_word[dsr_pkg::ST_DISP_ON_POS] = mode.disp_on;
      words.status_word[dsr_pkg::ST_TE_ON_POS] = mode.te_on;
      words.status_word[dsr_pkg::ST_GAMMA_LSB +: 3] = gamma;
      words.status_word[dsr_pkg::ST_TE_MODE_POS] = mode.te_mode;
      words.status_word[dsr_pkg::ST_SYNC_LSB +: 4] = sync_sel;
      words.power_mode = {1'b0, mode.idle, mode.partial, mode.sleep_out, mode.normal, mode.disp_on, 2'h0};
      words.memory_access = {mode.memory_access_control, 3'h0};
      words.pixel_format = {1'b0, rgb_port_format, 1'b0, host_port_format};
      words.image_mode = {2'h0, mode.invert, mode.all_on, mode.all_off, gamma};
   end

endmodule

// >>> logic/dsr_readback.sv
// Display status readback: command decode, snapshot and byte delivery
`timescale 1ns/100ps
// Operation
// - Status bits 30..26 copy memory access control bits B7..B3.
// - Reserved status bits 25, 24, 23, 15, 14 and 0 read zero.
// - Status bits 22..20 always read 111.
// - Status bits 19, 18, 16 show idle, partial, normal mode.
// - Status bit 17 low in sleep, high after sleep exit.
// - Status bits 13..9 show inversion, all on, all off, display, tearing.
// - Status bits 8..6 give gamma curve code, 111 if none chosen.
// - Status bit 5 gives tearing output mode.
// - Bits 4..1 give sync levels: pins in RGB mode, internal otherwise.
// - Power mode byte holds five flags in bits 6..2, rest zero.
// - Memory access byte holds B7..B3 in bits 7..3, rest zero.
// - Pixel format byte holds RGB format 6:4 and host format 2:0.
// - Pixel format bits 7 and 3 zero; 0x67 after any reset.
// - Image mode byte holds inversion, all on, all off in 5..3.
// - Image mode bits 2..0 give gamma code, 111 if none.
// - Status bit 31 reads zero.
// - Command 0x09 returns the 32-bit status word as bytes.
module dsr_readback
#(
   parameter int unsigned RESP_BYTES = dsr_pkg::STATUS_BYTES
)
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic SW_RESET,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic RD_REQ,
   input wire dsr_pkg::dsr_mode_t MODE,
   input wire dsr_pkg::dsr_sync_t EXT_SYNC,
   input wire dsr_pkg::dsr_sync_t INT_SYNC,
   input wire logic FMT_WR,
   input wire logic [2:0] FMT_RGB,
   input wire logic [2:0] FMT_HOST,
   output logic CMD_HIT,
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic RD_LAST,
   output logic BUSY,
   output logic [7:0] PIXEL_FORMAT
);

   localparam int unsigned SHIFT_W = RESP_BYTES * 8;

   // Status fields must cover the word once each; a gap or overlap would skew every byte lane
   localparam int unsigned FIELD_CNT = 32'h12;
   localparam int unsigned FIELD_LSB [FIELD_CNT] = '{
      dsr_pkg::ST_BOOSTER_POS,
      dsr_pkg::ST_MAC_LSB,
      dsr_pkg::ST_RSV_HI_LSB,
      dsr_pkg::ST_PIXFMT_LSB,
      dsr_pkg::ST_IDLE_POS,
      dsr_pkg::ST_PARTIAL_POS,
      dsr_pkg::ST_SLEEP_OUT_POS,
      dsr_pkg::ST_NORMAL_POS,
      dsr_pkg::ST_RSV_MID_LSB,
      dsr_pkg::ST_INVERT_POS,
      dsr_pkg::ST_ALL_ON_POS,
      dsr_pkg::ST_ALL_OFF_POS,
      dsr_pkg::ST_DISP_ON_POS,
      dsr_pkg::ST_TE_ON_POS,
      dsr_pkg::ST_GAMMA_LSB,
      dsr_pkg::ST_TE_MODE_POS,
      dsr_pkg::ST_SYNC_LSB,
      dsr_pkg::ST_PARITY_POS
   };
   localparam int unsigned FIELD_WID [FIELD_CNT] = '{
      32'h1, 32'h5, 32'h3, 32'h3, 32'h1, 32'h1, 32'h1, 32'h1, 32'h2,
      32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h3, 32'h1, 32'h4, 32'h1
   };

   function automatic logic [31:0] field_mask(input int unsigned lsb, input int unsigned width);
      logic [31:0] m;
      m = 32'((64'h1 << width) - 64'h1) << lsb;
      return m;
   endfunction

   function automatic bit layout_ok();
      logic [31:0] used;
      logic [31:0] m;
      bit ok;
      used = 32'h0000_0000;
      ok = 1'b1;
      for (int unsigned i = 32'h0; i < FIELD_CNT; i++)
      begin
         m = field_mask(FIELD_LSB[i], FIELD_WID[i]);
         ok = ok && ((used & m) == 32'h0000_0000);
         used = used | m;
      end
      return ok && (used == 32'hffff_ffff);
   endfunction

   if (!layout_ok())
   begin : g_layout_check
      $error("dsr_readback: status field positions do not tile 32 bits");
   end

   // Reserved format bits and the no-curve code are fixed by the readback layout
   if (dsr_pkg::PIXFMT_RST[7] != 1'b0 || dsr_pkg::PIXFMT_RST[3] != 1'b0)
   begin : g_pixfmt_check
      $error("dsr_readback: pixel format reset must keep bits 7 and 3 clear");
   end

   if (dsr_pkg::GAMMA_NONE[2] != 1'b1)
   begin : g_gamma_check
      $error("dsr_readback: no-curve code must not alias a curve code");
   end

   if (dsr_pkg::STATUS_BYTES * 32'h8 != 32'h20)
   begin : g_word_check
      $error("dsr_readback: status answer must be four bytes");
   end

   // The shift register must at least carry the status word
   if (RESP_BYTES < dsr_pkg::STATUS_BYTES)
   begin : g_size_check
      $error("dsr_readback: RESP_BYTES must be at least four");
   end

   typedef enum {
      DSR_IDLE,
      DSR_SEND
   } dsr_fsm_t;

   typedef struct packed {
      dsr_fsm_t fsm;
      logic [SHIFT_W-1:0] shift;
      logic [2:0] left;
      logic [2:0] rgb_fmt;
      logic [2:0] host_fmt;
      logic [7:0] rd_data;
      logic rd_valid;
      logic rd_last;
      logic cmd_hit;
      logic busy;
   } dsr_state_t;

   localparam dsr_state_t STATE_RST = '{
      fsm: DSR_IDLE,
      shift: '0,
      left: 3'h0,
      rgb_fmt: dsr_pkg::RGB_FMT_RST,
      host_fmt: dsr_pkg::HOST_FMT_RST,
      rd_data: 8'h00,
      rd_valid: 1'b0,
      rd_last: 1'b0,
      cmd_hit: 1'b0,
      busy: 1'b0
   };

   dsr_state_t state_q;
   dsr_state_t state_d;
   dsr_pkg::dsr_words_t words;
   logic known_cmd;
   logic [31:0] resp_word;
   logic [2:0] resp_len;

   dsr_status_pack u_pack
   (
      .mode(MODE),
      .ext_sync(EXT_SYNC),
      .int_sync(INT_SYNC),
      .rgb_port_format(state_q.rgb_fmt),
      .host_port_format(state_q.host_fmt),
      .words(words)
   );

   // Pick the answer for a decoded read command
   always_comb
   begin
      known_cmd = 1'b1;
      resp_word = 32'h0000_0000;
      resp_len = 3'(dsr_pkg::SHORT_BYTES);
      case (CMD_CODE)
         dsr_pkg::CMD_STATUS_WORD_READ:
         begin
            resp_word = words.status_word;
            resp_len = 3'(dsr_pkg::STATUS_BYTES);
         end
         dsr_pkg::CMD_POWER_MODE_READ:
         begin
            resp_word = {words.power_mode, 24'h00_0000};
         end
         dsr_pkg::CMD_MEMORY_ACCESS_READ:
         begin
            resp_word = {words.memory_access, 24'h00_0000};
         end
         dsr_pkg::CMD_PIXEL_FORMAT_READ:
         begin
            resp_word = {words.pixel_format, 24'h00_0000};
         end
         dsr_pkg::CMD_IMAGE_MODE_READ:
         begin
            resp_word = {words.image_mode, 24'h00_0000};
         end
         default:
         begin
            known_cmd = 1'b0;
            resp_len = 3'h0;
         end
      endcase
   end

   always_comb
   begin
      state_d = state_q;
      state_d.rd_valid = 1'b0;
      state_d.rd_last = 1'b0;
      state_d.cmd_hit = 1'b0;

      // format store and its reset value
      if (FMT_WR)
      begin
         state_d.rgb_fmt = FMT_RGB;
         state_d.host_fmt = FMT_HOST;
      end

      // Byte delivery; a fetch with nothing pending returns a zero byte
      if (RD_REQ)
      begin
         state_d.rd_valid = 1'b1;
         state_d.rd_data = 8'h00;
         if (state_q.fsm == DSR_SEND)
         begin
            state_d.rd_data = state_q.shift[SHIFT_W-1 -: 8];
            state_d.shift = {state_q.shift[SHIFT_W-9:0], 8'h00};
            state_d.left = state_q.left - 3'h1;
            if (state_q.left == 3'h1)
            begin
               state_d.rd_last = 1'b1;
               state_d.fsm = DSR_IDLE;
            end
         end
      end

      // A new command ends any unfinished answer
      if (CMD_VALID)
      begin
         state_d.fsm = DSR_IDLE;
         state_d.left = 3'h0;
         if (known_cmd)
         begin
            state_d.shift = '0;
            state_d.shift[SHIFT_W-1 -: 32] = resp_word;
            state_d.left = resp_len;
            state_d.fsm = DSR_SEND;
            state_d.cmd_hit = 1'b1;
         end
      end

      case (state_d.fsm)
         DSR_IDLE:
         begin
            state_d.left = 3'h0;
         end
         DSR_SEND:
         begin
         end
         default:
         begin
            state_d.fsm = DSR_IDLE;
         end
      endcase

      // BUSY leaves a flop directly rather than a state decode
      state_d.busy = (state_d.fsm == DSR_SEND);

      // Software reset restores the format and drops the answer
      if (SW_RESET)
      begin
         state_d = STATE_RST;
      end
   end

   // interface clock only, any power mode
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_q <= STATE_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign CMD_HIT = state_q.cmd_hit;
   assign RD_VALID = state_q.rd_valid;
   assign RD_DATA = state_q.rd_data;
   assign RD_LAST = state_q.rd_last;
   assign BUSY = state_q.busy;
   assign PIXEL_FORMAT = {1'b0, state_q.rgb_fmt, 1'b0, state_q.host_fmt};

endmodule

// >>> testbench/dsr_readback_monitor.sv
// Port checker for the display status readback block
`timescale 1ns/100ps
module dsr_readback_monitor
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic SW_RESET,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic RD_REQ,
   input wire dsr_pkg::dsr_mode_t MODE,
   input wire logic CMD_HIT,
   input wire logic RD_VALID,
   input wire logic [7:0] RD_DATA,
   input wire logic RD_LAST,
   input wire logic BUSY,
   input wire logic [7:0] PIXEL_FORMAT
);
   dsr_pkg::dsr_mode_t m1_q;
   dsr_pkg::dsr_mode_t m2_q;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   // Mode as it stood at the command edge, two edges back
   always_ff @(posedge MCLK)
   begin
      m1_q <= MODE;
      m2_q <= m1_q;
   end
   sequence s_rd(logic [7:0] c);
      CMD_VALID && CMD_CODE == c && !SW_RESET ##1 RD_REQ && !CMD_VALID && !SW_RESET;
   endsequence
   property p_hit; CMD_VALID && !SW_RESET && CMD_CODE inside {[8'h09:8'h0d]} |=> CMD_HIT; endproperty
   a_hit: assert property (p_hit) else $error("known command gave no hit");
   property p_miss; CMD_VALID && !(CMD_CODE inside {[8'h09:8'h0d]}) |=> !CMD_HIT && !BUSY; endproperty
   a_miss: assert property (p_miss) else $error("unknown command accepted");
   property p_fetch; !SW_RESET |=> RD_VALID == $past(RD_REQ); endproperty
   a_fetch: assert property (p_fetch) else $error("fetch answer timing wrong");
   property p_last; RD_LAST |-> RD_VALID && !BUSY; endproperty
   a_last: assert property (p_last) else $error("last byte with busy or no valid");
   property p_pfrst; SW_RESET |=> PIXEL_FORMAT == 8'h67; endproperty
   a_pfrst: assert property (p_pfrst) else $error("pixel format not restored");
   property p_pfz; CMD_HIT |-> PIXEL_FORMAT[7] == 1'b0 && PIXEL_FORMAT[3] == 1'b0; endproperty
   a_pfz: assert property (p_pfz) else $error("pixel format spare bits set");
   property p_pfrd; s_rd(8'h0c) |=> RD_DATA == $past(PIXEL_FORMAT, 2) && RD_LAST && !BUSY; endproperty
   a_pfrd: assert property (p_pfrd) else $error("pixel format byte wrong");
   property p_pm; s_rd(8'h0a) |=> RD_DATA == {1'b0, m2_q.idle, m2_q.partial, m2_q.sleep_out, m2_q.normal,
      m2_q.disp_on, 2'h0}; endproperty
   a_pm: assert property (p_pm) else $error("power mode byte wrong");
   property p_mac; s_rd(8'h0b) |=> RD_DATA == {m2_q.memory_access_control, 3'h0}; endproperty
   a_mac: assert property (p_mac) else $error("memory access byte wrong");
   property p_st; s_rd(8'h09) |=> RD_DATA == {1'b0, m2_q.memory_access_control, 2'h0} && BUSY; endproperty
   a_st: assert property (p_st) else $error("status high byte wrong");
endmodule
bind dsr_readback dsr_readback_monitor u_mon (.MCLK(MCLK), .RST_B(RST_B), .SW_RESET(SW_RESET),
   .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .RD_REQ(RD_REQ), .MODE(MODE), .CMD_HIT(CMD_HIT),
   .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .RD_LAST(RD_LAST), .BUSY(BUSY), .PIXEL_FORMAT(PIXEL_FORMAT));

// >>> testbench/dsr_host_model.sv
// Host model that sends read commands and fetches the answer bytes
`timescale 1ns/100ps
module dsr_host_model
(
   input wire logic MCLK,
   input wire logic CMD_HIT,
   input wire logic RD_VALID,
   input wire logic [7:0] RD_DATA,
   input wire logic RD_LAST,
   output logic CMD_VALID,
   output logic [7:0] CMD_CODE,
   output logic RD_REQ
);
   initial
   begin
      CMD_VALID = 1'b0;
      CMD_CODE = 8'h00;
      RD_REQ = 1'b0;
   end
   // One command, then n fetches back to back
   task automatic xfer(input logic [7:0] c, input int n, output logic hit, output logic [31:0] w,
      output logic last);
      int i;
      @(negedge MCLK);
      CMD_VALID = 1'b1;
      CMD_CODE = c;
      @(negedge MCLK);
      CMD_VALID = 1'b0;
      // Code lines are not held past the strobe
      CMD_CODE = ~c;
      hit = CMD_HIT;
      w = 32'h0;
      last = 1'b0;
      for (i = 0; i < n; i++)
      begin
         RD_REQ = 1'b1;
         @(negedge MCLK);
         w = RD_VALID ? {w[23:0], RD_DATA} : 32'hx;
         last = RD_LAST;
      end
      RD_REQ = 1'b0;
   endtask
endmodule

// >>> testbench/dsr_readback_tb.sv
// Self-checking bench for the display status readback block
`timescale 1ns/100ps
module dsr_readback_tb;
   logic MCLK, RST_B, SW_RESET, FMT_WR, CMD_VALID, RD_REQ, CMD_HIT, RD_VALID, RD_LAST, BUSY, hit, last;
   logic [7:0] CMD_CODE, RD_DATA, PIXEL_FORMAT, pf, c;
   logic [2:0] FMT_RGB, FMT_HOST;
   logic [31:0] seed, w;
   dsr_pkg::dsr_mode_t MODE, m;
   dsr_pkg::dsr_sync_t EXT_SYNC, INT_SYNC, s;
   int n_errors, tests_run, i;
   dsr_readback DUT (.MCLK(MCLK), .RST_B(RST_B), .SW_RESET(SW_RESET), .CMD_VALID(CMD_VALID),
      .CMD_CODE(CMD_CODE), .RD_REQ(RD_REQ), .MODE(MODE), .EXT_SYNC(EXT_SYNC), .INT_SYNC(INT_SYNC),
      .FMT_WR(FMT_WR), .FMT_RGB(FMT_RGB), .FMT_HOST(FMT_HOST), .CMD_HIT(CMD_HIT), .RD_VALID(RD_VALID),
      .RD_DATA(RD_DATA), .RD_LAST(RD_LAST), .BUSY(BUSY), .PIXEL_FORMAT(PIXEL_FORMAT));
   dsr_host_model host (.MCLK(MCLK), .CMD_HIT(CMD_HIT), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
      .RD_LAST(RD_LAST), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .RD_REQ(RD_REQ));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [2:0] gc(input dsr_pkg::dsr_mode_t x);
      return x.gamma_chosen ? {1'b0, x.gamma_curve} : 3'h7;
   endfunction
   function automatic logic [31:0] expw(input logic [7:0] k, input dsr_pkg::dsr_mode_t x,
      input dsr_pkg::dsr_sync_t y, input logic [7:0] p);
      case (k)
         8'h09: return {1'b0, x.memory_access_control, 3'h0, 3'h7, x.idle, x.partial, x.sleep_out, x.normal,
            2'h0, x.invert, x.all_on, x.all_off, x.disp_on, x.te_on, gc(x), x.te_mode, y, 1'b0};
         8'h0a: return {25'h0, x.idle, x.partial, x.sleep_out, x.normal, x.disp_on, 2'h0};
         8'h0b: return {24'h0, x.memory_access_control, 3'h0};
         8'h0c: return {24'h0, p};
         default: return {26'h0, x.invert, x.all_on, x.all_off, gc(x)};
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] k, input int n);
      host.xfer(k, n, hit, w, last);
   endtask
   task automatic pulse_fmt();
      @(negedge MCLK);
      FMT_WR = 1'b1;
      @(negedge MCLK);
      FMT_WR = 1'b0;
   endtask
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial
   begin
      seed = 32'hc7c1c2f2;
      n_errors = 0;
      tests_run = 0;
      {RST_B, SW_RESET, FMT_WR} = 3'h0;
      {FMT_RGB, FMT_HOST} = 6'h15;
      MODE = '0;
      EXT_SYNC = '0;
      INT_SYNC = '1;
      repeat (3) @(negedge MCLK);
      RST_B = 1'b1;
      rd(8'h0c, 1);
      chk("pixfmt reset", 32'h67, w);
      chk("single last", 32'h1, {31'h0, last});
      pulse_fmt();
      rd(8'h0c, 1);
      chk("pixfmt store", 32'h25, w);
      @(negedge MCLK);
      SW_RESET = 1'b1;
      @(negedge MCLK);
      SW_RESET = 1'b0;
      chk("pixfmt port", 32'h67, {24'h0, PIXEL_FORMAT});
      // Unknown code: no hit, empty fetch reads zero
      rd(8'h0e, 1);
      chk("unknown hit", 32'h0, {31'h0, hit});
      chk("empty fetch", 32'h0, w);
      // A new command drops the bytes still pending from the last one
      rd(8'h09, 1);
      chk("busy pending", 32'h1, {31'h0, BUSY});
      rd(8'h0e, 1);
      chk("abort fetch", 32'h0, w);
      chk("abort busy", 32'h0, {31'h0, BUSY});
      for (i = 0; i < 60; i++)
      begin
         w = rnd();
         MODE = w[18:0];
         EXT_SYNC = w[22:19];
         INT_SYNC = w[26:23];
         FMT_RGB = w[29:27];
         FMT_HOST = {w[31:30], w[0]};
         pulse_fmt();
         pf = {1'b0, FMT_RGB, 1'b0, FMT_HOST};
         m = MODE;
         s = m.rgb_mode ? EXT_SYNC : INT_SYNC;
         c = 8'h09 + 8'(i % 5);
         // Mode moves after the command edge; the answer must not follow it
         fork
            rd(c, (c == 8'h09) ? 4 : 1);
            begin
               repeat (2) @(negedge MCLK);
               MODE = ~MODE;
               EXT_SYNC = ~EXT_SYNC;
               INT_SYNC = ~INT_SYNC;
            end
         join
         chk("hit", 32'h1, {31'h0, hit});
         chk("answer", expw(c, m, s, pf), w);
         chk("last", 32'h1, {31'h0, last});
      end
      // Hardware reset mid-run restores the format and drops a pending answer
      {FMT_RGB, FMT_HOST} = 6'h15;
      pulse_fmt();
      chk("format before reset", 32'h25, {24'h0, PIXEL_FORMAT});
      rd(8'h09, 1);
      RST_B = 1'b0;
      @(negedge MCLK);
      RST_B = 1'b1;
      chk("reset format", 32'h67, {24'h0, PIXEL_FORMAT});
      chk("reset busy", 32'h0, {31'h0, BUSY});
      test_done();
   end
endmodule
